// >>> prot_pkg.sv
// constants and types shared by the protection command block
//
// How it works
// - otp write needs write-enable latch set first
// - zeros into locked otp region flag error
// - programming only clears bits, ones keep
// - otp write framed like page program
// - otp read has exactly one dummy byte
// - otp read never wraps past top
// - sample input on rise, shift out on fall
// - protect register read low byte then high byte, repeats
// - protect program executes only after sixteen bits
// - protection writes update error and busy bits
// - busy held during operation, clears latch after
// - volatile lock read returns byte, repeating
// - lock reads never advance the address
// - volatile lock write needs exact byte framing
// - persistent lock read returns repeating byte
// - persistent program ends right after address
// - persistent erase sets all, opcode only
// - no erase suspend during persistent erase
// - lock gate read repeats, standby only
// - lock gate clear zeroes register after enable
package prot_pkg;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
   localparam logic [7:0] OP_OTP_WRITE = 8'h42;
   localparam logic [7:0] OP_OTP_READ = 8'h4B;
   localparam logic [7:0] OP_PROT_READ = 8'h2B;
   localparam logic [7:0] OP_PROT_PROGRAM = 8'h2F;
   localparam logic [7:0] OP_VOL_READ = 8'hE0;
   localparam logic [7:0] OP_VOL_WRITE = 8'hE1;
   localparam logic [7:0] OP_PERS_READ = 8'hE2;
   localparam logic [7:0] OP_PERS_PROGRAM = 8'hE3;
   localparam logic [7:0] OP_PERS_ERASE = 8'hE4;
   localparam logic [7:0] OP_GATE_READ = 8'hA7;
   localparam logic [7:0] OP_GATE_CLEAR = 8'hA6;
   localparam int OTP_AW = 10;
   localparam int OTP_REGION_LSB = 5;
   localparam int OTP_REGIONS = 32;
   localparam logic [OTP_AW-1:0] OTP_LOCK_ADDR = 10'h010;
   localparam logic [OTP_REGIONS-1:0] OTP_LOCK_RESET = 32'hFFFFFFFF;
   localparam int SECTOR_LSB = 16;
   localparam int SECTOR_AW = 8;
   localparam int NUM_SECTORS = 256;
   localparam logic [2:0] OTP_ADDR_LAST = 3'h2;
   localparam logic [2:0] SECT_ADDR_LAST = 3'h3;
   localparam logic [15:0] PROT_MODE_RESET = 16'hFFFF;
   localparam logic [7:0] GATE_RESET = 8'h01;
   localparam logic [7:0] LOCK_OPEN_BYTE = 8'hFF;
   localparam int SR_WIP_BIT = 0;
   localparam int SR_WEL_BIT = 1;
   localparam int SR_PERR_BIT = 6;
   localparam int BUSY_W = 24;
   localparam longint CLK_PERIOD_NS = 50;
   localparam longint PROG_TIME_NS = 750000;
   localparam longint ERASE_TIME_NS = 650000000;
   localparam logic [BUSY_W-1:0] PROG_CYCLES_DEF = BUSY_W'(PROG_TIME_NS / CLK_PERIOD_NS);
   localparam logic [BUSY_W-1:0] ERASE_CYCLES_DEF = BUSY_W'(ERASE_TIME_NS / CLK_PERIOD_NS);
   typedef enum logic [4:0] {
      ST_OP = 5'h01,
      ST_ADDR = 5'h02,
      ST_DUMMY = 5'h04,
      ST_DATA = 5'h08,
      ST_SKIP = 5'h10
   } frame_state_t;
endpackage

// >>> otp_mem_if.sv
// carrier between the command logic and the otp storage
`timescale 1ns/10ps
`default_nettype none
interface otp_mem_if;
   logic [prot_pkg::OTP_AW-1:0] rd_addr;
   logic [7:0] rd_data;
   logic wr_en;
   logic [prot_pkg::OTP_AW-1:0] wr_addr;
   logic [7:0] wr_data;
   modport ctrl (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
   modport mem (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface
`default_nettype wire

// >>> otp_mem.sv
// one-time-program storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module otp_mem (
   // clock
   input wire logic i_clk,
   // storage port
   otp_mem_if.mem bus
);
   logic [7:0] mem_ff [0:(1 << prot_pkg::OTP_AW)-1];

   // blank otp reads as all ones
   initial begin
      for (int i = 0; i < (1 << prot_pkg::OTP_AW); i++) begin
         mem_ff[i] = 8'hFF;
      end
   end

   always_ff @(posedge i_clk) begin
      if (bus.wr_en) begin
         mem_ff[bus.wr_addr] <= bus.wr_data;
      end
      bus.rd_data <= mem_ff[bus.rd_addr];
   end
endmodule // otp_mem
`default_nettype wire

// >>> prot_cmd_top.sv
// serial command engine for otp and sector protection state
`timescale 1ns/10ps
`default_nettype none
module prot_cmd_top #(
   parameter logic [prot_pkg::BUSY_W-1:0] PROG_CYCLES = prot_pkg::PROG_CYCLES_DEF,
   parameter logic [prot_pkg::BUSY_W-1:0] ERASE_CYCLES = prot_pkg::ERASE_CYCLES_DEF
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // serial link
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_si,
   output logic o_so,
   output logic o_so_oe
);

   otp_mem_if mbus ();
   otp_mem u_mem (.i_clk(i_clk), .bus(mbus));

   // pin synchronisers: logic reads only stages 1 and 2
   logic [2:0] cs_sync_ff, sck_sync_ff, si_sync_ff;
   logic cs_lvl_ff, sck_lvl_ff;
   logic cs_stable, sck_stable, cs_rise, cs_fall, sck_rise, sck_fall, byte_done;
   logic [7:0] rx;

   prot_pkg::frame_state_t state_ff, nxt_state;
   logic [2:0] bit_ff, nxt_bit, cnt_ff, nxt_cnt;
   logic [7:0] cmd_ff, nxt_cmd, sh_ff, nxt_sh, tx_ff, nxt_tx, d0_ff, nxt_d0, d1_ff, nxt_d1;
   logic [31:0] addr_ff, nxt_addr;
   logic [prot_pkg::OTP_AW:0] otp_addr_ff, nxt_otp_addr;
   logic complete_ff, nxt_complete, out_ff, nxt_out, tgl_ff, nxt_tgl, so_ff, nxt_so;
   logic wel_ff, nxt_wel, wip_ff, nxt_wip, perr_ff, nxt_perr;
   logic [prot_pkg::BUSY_W-1:0] busy_cnt_ff, nxt_busy_cnt;
   logic [15:0] mode_ff, nxt_mode;
   logic [7:0] gate_ff, nxt_gate;
   logic [prot_pkg::NUM_SECTORS-1:0] vol_ff, nxt_vol, pers_ff, nxt_pers;
   logic [prot_pkg::OTP_REGIONS-1:0] lock_ff, nxt_lock;
   logic [prot_pkg::SECTOR_AW-1:0] sect, new_sect;
   logic [31:0] new_addr;
   logic [7:0] otp_byte, status_byte;
   logic otp_locked;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cs_sync_ff <= 3'h7;
         sck_sync_ff <= 3'h0;
         si_sync_ff <= 3'h0;
      end else begin
         cs_sync_ff <= {cs_sync_ff[1:0], i_cs_n};
         sck_sync_ff <= {sck_sync_ff[1:0], i_sck};
         si_sync_ff <= {si_sync_ff[1:0], i_si};
      end
   end

   assign cs_stable = cs_sync_ff[1] == cs_sync_ff[2];
   assign sck_stable = sck_sync_ff[1] == sck_sync_ff[2];
   assign cs_rise = cs_stable && cs_sync_ff[2] && !cs_lvl_ff;
   assign cs_fall = cs_stable && !cs_sync_ff[2] && cs_lvl_ff;
   // edges only count inside a frame; clock may idle either level
   assign sck_rise = sck_stable && sck_sync_ff[2] && !sck_lvl_ff && !cs_lvl_ff;
   assign sck_fall = sck_stable && !sck_sync_ff[2] && sck_lvl_ff && !cs_lvl_ff;
   assign rx = {sh_ff[6:0], si_sync_ff[2]};
   assign byte_done = sck_rise && (bit_ff == 3'h7);

   assign new_addr = {addr_ff[23:0], rx};
   assign sect = addr_ff[prot_pkg::SECTOR_LSB +: prot_pkg::SECTOR_AW];
   assign new_sect = new_addr[prot_pkg::SECTOR_LSB +: prot_pkg::SECTOR_AW];
   // past the top the output is undefined; ones are driven
   assign otp_byte = otp_addr_ff[prot_pkg::OTP_AW] ? 8'hFF : mbus.rd_data;
   assign otp_locked = !lock_ff[otp_addr_ff[prot_pkg::OTP_AW-1:prot_pkg::OTP_REGION_LSB]];
   assign mbus.rd_addr = otp_addr_ff[prot_pkg::OTP_AW-1:0];
   assign mbus.wr_addr = otp_addr_ff[prot_pkg::OTP_AW-1:0];
   assign mbus.wr_data = mbus.rd_data & rx;

   always_comb begin
      status_byte = 8'h00;
      status_byte[prot_pkg::SR_WIP_BIT] = wip_ff;
      status_byte[prot_pkg::SR_WEL_BIT] = wel_ff;
      status_byte[prot_pkg::SR_PERR_BIT] = perr_ff;
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_bit = bit_ff;
      nxt_cnt = cnt_ff;
      nxt_cmd = cmd_ff;
      nxt_sh = sh_ff;
      nxt_tx = tx_ff;
      nxt_d0 = d0_ff;
      nxt_d1 = d1_ff;
      nxt_addr = addr_ff;
      nxt_otp_addr = otp_addr_ff;
      nxt_complete = complete_ff;
      nxt_out = out_ff;
      nxt_tgl = tgl_ff;
      nxt_so = so_ff;
      nxt_wel = wel_ff;
      nxt_wip = wip_ff;
      nxt_perr = perr_ff;
      nxt_busy_cnt = busy_cnt_ff;
      nxt_mode = mode_ff;
      nxt_gate = gate_ff;
      nxt_vol = vol_ff;
      nxt_pers = pers_ff;
      nxt_lock = lock_ff;
      mbus.wr_en = 1'b0;
      // self-timed countdown; completion drops the latch too
      if (wip_ff) begin
         if (busy_cnt_ff <= {{(prot_pkg::BUSY_W-1){1'b0}}, 1'b1}) begin
            nxt_wip = 1'b0;
            nxt_wel = 1'b0;
            nxt_busy_cnt = '0;
         end else begin
            nxt_busy_cnt = busy_cnt_ff - {{(prot_pkg::BUSY_W-1){1'b0}}, 1'b1};
         end
      end
      if (cs_fall) begin
         nxt_state = prot_pkg::ST_OP;
         nxt_bit = 3'h0;
         nxt_cnt = 3'h0;
         nxt_complete = 1'b0;
         nxt_out = 1'b0;
      end
      if (cs_rise) begin
         nxt_out = 1'b0;
         // a frame cut short or overrun leaves complete low and does nothing
         if (complete_ff) begin
            case (cmd_ff)
               prot_pkg::OP_WRITE_ENABLE: nxt_wel = 1'b1;
               prot_pkg::OP_CLEAR_STATUS: nxt_perr = 1'b0;
               default: begin
                  // nothing happens, status included, without the latch
                  if (wel_ff) begin
                     nxt_wip = 1'b1;
                     nxt_busy_cnt = PROG_CYCLES;
                     case (cmd_ff)
                        prot_pkg::OP_PROT_PROGRAM: nxt_mode = mode_ff & {d1_ff, d0_ff};
                        prot_pkg::OP_VOL_WRITE: nxt_vol[sect] = (d0_ff == prot_pkg::LOCK_OPEN_BYTE);
                        prot_pkg::OP_PERS_PROGRAM: begin
                           if (gate_ff[0]) begin
                              nxt_pers[sect] = 1'b0;
                           end else begin
                              nxt_perr = 1'b1;
                           end
                        end
                        prot_pkg::OP_PERS_ERASE: begin
                           // erase runs its full time; suspend is never honoured
                           nxt_busy_cnt = ERASE_CYCLES;
                           if (gate_ff[0]) begin
                              nxt_pers = '1;
                           end else begin
                              nxt_perr = 1'b1;
                           end
                        end
                        prot_pkg::OP_GATE_CLEAR: nxt_gate = 8'h00;
                        default: nxt_gate = gate_ff;
                     endcase
                  end
               end
            endcase
         end
         nxt_complete = 1'b0;
      end
      if (sck_fall && out_ff) begin
         nxt_so = tx_ff[7];
         nxt_tx = {tx_ff[6:0], 1'b0};
      end
      if (sck_rise) begin
         nxt_sh = rx;
         nxt_bit = bit_ff + 3'h1;
         nxt_complete = 1'b0;
      end
      if (byte_done) begin
         case (state_ff)
            prot_pkg::ST_OP: begin
               nxt_cmd = rx;
               nxt_cnt = 3'h0;
               nxt_state = prot_pkg::ST_SKIP;
               case (rx)
                  prot_pkg::OP_STATUS_READ: begin
                     nxt_state = prot_pkg::ST_DATA;
                     nxt_tx = status_byte;
                     nxt_out = 1'b1;
                  end
                  prot_pkg::OP_PROT_READ: begin
                     nxt_state = prot_pkg::ST_DATA;
                     nxt_tx = mode_ff[7:0];
                     nxt_tgl = 1'b1;
                     nxt_out = 1'b1;
                  end
                  prot_pkg::OP_GATE_READ: begin
                     nxt_state = prot_pkg::ST_DATA;
                     nxt_tx = gate_ff;
                     nxt_out = 1'b1;
                  end
                  prot_pkg::OP_OTP_WRITE, prot_pkg::OP_OTP_READ, prot_pkg::OP_VOL_READ,
                  prot_pkg::OP_VOL_WRITE, prot_pkg::OP_PERS_READ, prot_pkg::OP_PERS_PROGRAM:
                     nxt_state = prot_pkg::ST_ADDR;
                  prot_pkg::OP_PROT_PROGRAM: nxt_state = prot_pkg::ST_DATA;
                  prot_pkg::OP_WRITE_ENABLE, prot_pkg::OP_CLEAR_STATUS,
                  prot_pkg::OP_PERS_ERASE, prot_pkg::OP_GATE_CLEAR:
                     nxt_complete = 1'b1;
                  default: nxt_state = prot_pkg::ST_SKIP;
               endcase
               // while busy only status reads are served
               if (wip_ff && rx != prot_pkg::OP_STATUS_READ) begin
                  nxt_state = prot_pkg::ST_SKIP;
                  nxt_complete = 1'b0;
                  nxt_out = 1'b0;
               end
            end
            prot_pkg::ST_ADDR: begin
               nxt_addr = new_addr;
               nxt_cnt = cnt_ff + 3'h1;
               nxt_otp_addr = {1'b0, new_addr[prot_pkg::OTP_AW-1:0]};
               if ((cmd_ff == prot_pkg::OP_OTP_READ || cmd_ff == prot_pkg::OP_OTP_WRITE) ?
                   (cnt_ff == prot_pkg::OTP_ADDR_LAST) : (cnt_ff == prot_pkg::SECT_ADDR_LAST)) begin
                  nxt_cnt = 3'h0;
                  nxt_state = prot_pkg::ST_DATA;
                  case (cmd_ff)
                     prot_pkg::OP_OTP_READ: nxt_state = prot_pkg::ST_DUMMY;
                     prot_pkg::OP_VOL_READ: begin
                        nxt_tx = {8{vol_ff[new_sect]}};
                        nxt_out = 1'b1;
                     end
                     prot_pkg::OP_PERS_READ: begin
                        nxt_tx = {8{pers_ff[new_sect]}};
                        nxt_out = 1'b1;
                     end
                     prot_pkg::OP_PERS_PROGRAM: begin
                        nxt_state = prot_pkg::ST_SKIP;
                        nxt_complete = 1'b1;
                     end
                     default: nxt_state = prot_pkg::ST_DATA;
                  endcase
               end
            end
            prot_pkg::ST_DUMMY: begin
               nxt_state = prot_pkg::ST_DATA;
               nxt_tx = otp_byte;
               nxt_out = 1'b1;
               nxt_otp_addr = otp_addr_ff + {{prot_pkg::OTP_AW{1'b0}}, !otp_addr_ff[prot_pkg::OTP_AW]};
            end
            prot_pkg::ST_DATA: begin
               case (cmd_ff)
                  prot_pkg::OP_STATUS_READ: nxt_tx = status_byte;
                  prot_pkg::OP_PROT_READ: begin
                     nxt_tx = tgl_ff ? mode_ff[15:8] : mode_ff[7:0];
                     nxt_tgl = !tgl_ff;
                  end
                  prot_pkg::OP_GATE_READ: nxt_tx = gate_ff;
                  // address stays put, so the same byte repeats
                  prot_pkg::OP_VOL_READ: nxt_tx = {8{vol_ff[sect]}};
                  prot_pkg::OP_PERS_READ: nxt_tx = {8{pers_ff[sect]}};
                  prot_pkg::OP_OTP_READ: begin
                     nxt_tx = otp_byte;
                     // address saturates above the top: no wrap
                     nxt_otp_addr = otp_addr_ff + {{prot_pkg::OTP_AW{1'b0}}, !otp_addr_ff[prot_pkg::OTP_AW]};
                  end
                  prot_pkg::OP_PROT_PROGRAM: begin
                     nxt_cnt = cnt_ff + 3'h1;
                     if (cnt_ff == 3'h0) begin
                        nxt_d0 = rx;
                     end else begin
                        nxt_d1 = rx;
                        nxt_state = prot_pkg::ST_SKIP;
                        nxt_complete = 1'b1;
                     end
                  end
                  prot_pkg::OP_VOL_WRITE: begin
                     nxt_d0 = rx;
                     nxt_state = prot_pkg::ST_SKIP;
                     nxt_complete = 1'b1;
                  end
                  prot_pkg::OP_OTP_WRITE: begin
                     nxt_complete = 1'b1;
                     if (wel_ff && !otp_addr_ff[prot_pkg::OTP_AW]) begin
                        if (otp_locked && rx != 8'hFF) begin
                           nxt_perr = 1'b1;
                        end else begin
                           mbus.wr_en = 1'b1;
                           if (otp_addr_ff[prot_pkg::OTP_AW-1:2] == prot_pkg::OTP_LOCK_ADDR[prot_pkg::OTP_AW-1:2]) begin
                              nxt_lock[{otp_addr_ff[1:0], 3'h0} +: 8] = lock_ff[{otp_addr_ff[1:0], 3'h0} +: 8] & rx;
                           end
                        end
                     end
                     nxt_otp_addr = otp_addr_ff + {{prot_pkg::OTP_AW{1'b0}}, !otp_addr_ff[prot_pkg::OTP_AW]};
                  end
                  default: nxt_state = prot_pkg::ST_SKIP;
               endcase
            end
            default: nxt_state = prot_pkg::ST_SKIP;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cs_lvl_ff <= 1'b1;
         sck_lvl_ff <= 1'b0;
         state_ff <= prot_pkg::ST_OP;
         bit_ff <= 3'h0;
         cnt_ff <= 3'h0;
         cmd_ff <= 8'h00;
         sh_ff <= 8'h00;
         tx_ff <= 8'h00;
         d0_ff <= 8'h00;
         d1_ff <= 8'h00;
         addr_ff <= 32'h00000000;
         otp_addr_ff <= '0;
         complete_ff <= 1'b0;
         out_ff <= 1'b0;
         tgl_ff <= 1'b0;
         so_ff <= 1'b0;
         wel_ff <= 1'b0;
         wip_ff <= 1'b0;
         perr_ff <= 1'b0;
         busy_cnt_ff <= '0;
         mode_ff <= prot_pkg::PROT_MODE_RESET;
         gate_ff <= prot_pkg::GATE_RESET;
         vol_ff <= '1;
         pers_ff <= '1;
         lock_ff <= prot_pkg::OTP_LOCK_RESET;
      end else begin
         if (cs_stable) cs_lvl_ff <= cs_sync_ff[2];
         if (sck_stable) sck_lvl_ff <= sck_sync_ff[2];
         state_ff <= nxt_state;
         bit_ff <= nxt_bit;
         cnt_ff <= nxt_cnt;
         cmd_ff <= nxt_cmd;
         sh_ff <= nxt_sh;
         tx_ff <= nxt_tx;
         d0_ff <= nxt_d0;
         d1_ff <= nxt_d1;
         addr_ff <= nxt_addr;
         otp_addr_ff <= nxt_otp_addr;
         complete_ff <= nxt_complete;
         out_ff <= nxt_out;
         tgl_ff <= nxt_tgl;
         so_ff <= nxt_so;
         wel_ff <= nxt_wel;
         wip_ff <= nxt_wip;
         perr_ff <= nxt_perr;
         busy_cnt_ff <= nxt_busy_cnt;
         mode_ff <= nxt_mode;
         gate_ff <= nxt_gate;
         vol_ff <= nxt_vol;
         pers_ff <= nxt_pers;
         lock_ff <= nxt_lock;
      end
   end

   assign o_so = so_ff;
   assign o_so_oe = out_ff && !cs_lvl_ff;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_dummy_done;
      state_ff == prot_pkg::ST_DUMMY && byte_done;
   endsequence
   sequence s_data_loaded;
      state_ff == prot_pkg::ST_DATA && out_ff;
   endsequence

   a_wip_needs_wel: assert property ($rose(wip_ff) |-> $past(wel_ff))
      else $error("busy started without write enable");
   a_done_clears_wel: assert property ($fell(wip_ff) |-> !wel_ff && busy_cnt_ff == '0)
      else $error("write enable survived completion");
   a_busy_counts: assert property (wip_ff && busy_cnt_ff > 24'h1 |=> wip_ff && busy_cnt_ff < $past(busy_cnt_ff))
      else $error("busy counter stalled or busy dropped early");
   a_locked_zero_err: assert property (byte_done && state_ff == prot_pkg::ST_DATA
      && cmd_ff == prot_pkg::OP_OTP_WRITE && wel_ff && !otp_addr_ff[prot_pkg::OTP_AW] && otp_locked
      && rx != 8'hFF |-> !mbus.wr_en ##1 perr_ff)
      else $error("locked otp program did not fail");
   a_one_dummy: assert property (s_dummy_done |=> s_data_loaded)
      else $error("otp read data not after one dummy byte");
   a_otp_no_wrap: assert property (byte_done && state_ff == prot_pkg::ST_DATA
      && cmd_ff == prot_pkg::OP_OTP_READ |=> otp_addr_ff >= $past(otp_addr_ff))
      else $error("otp read address wrapped");
   a_so_on_fall: assert property (!$stable(o_so) |-> $past(sck_fall))
      else $error("serial output moved off a falling edge");
   a_sector_addr_hold: assert property (state_ff == prot_pkg::ST_DATA
      && (cmd_ff == prot_pkg::OP_VOL_READ || cmd_ff == prot_pkg::OP_PERS_READ) |=> $stable(addr_ff))
      else $error("sector address advanced during lock read");
   a_short_frame_void: assert property (cs_rise && !complete_ff && !wip_ff |=> !wip_ff)
      else $error("incomplete frame started an operation");
endmodule // prot_cmd_top
`default_nettype wire

// >>> spi_host_model.sv
// serial host model that frames commands into the protection block
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
   // clock
   input wire logic i_clk,
   // serial link
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si,
   input wire logic i_so
);
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b0;
   end
   // four clocks a half period gives a 400 ns sck period, right at the rate ceiling for read data
   task automatic half();
      repeat (4) @(posedge i_clk);
      #5;
   endtask
   task automatic frame(input logic [63:0] tx, input int nt, input int nr, output logic [15:0] rx);
      rx = 16'h0000;
      half();
      o_cs_n = 1'b0;
      for (int i = 0; i < nt + nr; i++) begin
         o_si = (i < nt) ? tx[nt-1-i] : ~o_si;
         half();
         o_sck = 1'b1;
         if (i >= nt) rx = {rx[14:0], i_so};
         half();
         o_sck = 1'b0;
      end
      half();
      // cs rises a half period after the last falling edge; data line flips so no stale level
      o_cs_n = 1'b1;
      o_si = ~o_si;
      half();
   endtask
endmodule // spi_host_model
`default_nettype wire

// >>> prot_cmd_top_bench.sv
// self-checking bench for the protection command block
`timescale 1ns/10ps
`default_nettype none
module prot_cmd_top_bench;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic cs_n, sck, si, so, so_oe;
   logic oe_seen = 1'b0;
   logic [15:0] rx;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   always #25 i_clk = ~i_clk;
   // busy times long enough that a status frame still sees them running
   prot_cmd_top #(.PROG_CYCLES(24'h190), .ERASE_CYCLES(24'h320)) dut (.i_clk(i_clk), .i_rst(i_rst),
      .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe));
   spi_host_model host (.i_clk(i_clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so));
   task automatic finish_test();
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors++;
         finish_test();
      end
   end
   // remembers whether the block drove the output at all during a frame
   always @(posedge i_clk) begin
      if (so_oe === 1'b1) oe_seen <= 1'b1;
   end
   // otp addresses keep bits 23..10 zero
   task automatic x(input logic [63:0] t, input int nt, input int nr);
      oe_seen = 1'b0;
      host.frame(t, nt, nr, rx);
      chk({15'h0000, oe_seen}, {15'h0000, nr > 0});
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic we();
      x(64'h06, 8, 0);
   endtask
   task automatic sr(input logic [7:0] e);
      x(64'h05, 8, 8);
      chk(rx, {8'h00, e});
   endtask
   task automatic idle();
      repeat (40) begin
         x(64'h05, 8, 8);
         if (rx[0] === 1'b0) break;
      end
      chk({15'h0000, rx[0]}, 16'h0000);
   endtask
   task automatic t_prot();
      x(64'h2B, 8, 32);
      chk(rx, 16'hFFFF);
      x(64'h2FA53C, 24, 0);
      sr(8'h00);
      we();
      sr(8'h02);
      x(64'h2FA53C, 24, 0);
      sr(8'h03);
      idle();
      sr(8'h00);
      we();
      x(64'h178000, 23, 0);
      x(64'h2B, 8, 32);
      chk(rx, 16'hA53C);
      $display("t_prot done");
   endtask
   task automatic t_sect();
      we();
      x(64'h708002800000, 47, 0);
      x(64'hE000050000, 40, 16);
      chk(rx, 16'hFFFF);
      we();
      x(64'hE10005000000, 48, 0);
      idle();
      x(64'hE000050000, 40, 16);
      chk(rx, 16'h0000);
      x(64'hE000060000, 40, 8);
      chk(rx, 16'h00FF);
      we();
      x(64'hE300050000, 40, 0);
      idle();
      x(64'hE200050000, 40, 16);
      chk(rx, 16'h0000);
      we();
      x(64'hE4, 8, 0);
      sr(8'h03);
      idle();
      x(64'hE200050000, 40, 16);
      chk(rx, 16'hFFFF);
      $display("t_sect done");
   endtask
   task automatic t_otp();
      we();
      x(64'h420001005AF0, 48, 0);
      idle();
      x(64'h4B00010000, 40, 16);
      chk(rx, 16'h5AF0);
      we();
      x(64'h420001010F, 40, 0);
      idle();
      we();
      x(64'h42000011FE, 40, 0);
      idle();
      we();
      x(64'h4200010000, 40, 0);
      idle();
      x(64'h05, 8, 8);
      chk({15'h0, rx[6]}, 16'h0001);
      x(64'h30, 8, 0);
      we();
      x(64'h42000100FF, 40, 0);
      idle();
      sr(8'h00);
      x(64'h4B00010000, 40, 16);
      chk(rx, 16'h5A00);
      // byte 000 is made 00 so a wrapped read would show up
      we();
      x(64'h420003FF12, 40, 0);
      idle();
      we();
      x(64'h4200000000, 40, 0);
      idle();
      x(64'h4B0003FF00, 40, 16);
      chk(rx, 16'h12FF);
      $display("t_otp done");
   endtask
   task automatic t_gate();
      x(64'hA7, 8, 16);
      chk(rx, 16'h0101);
      we();
      x(64'hA6, 8, 0);
      idle();
      x(64'hA7, 8, 8);
      chk(rx, 16'h0000);
      we();
      x(64'hE300050000, 40, 0);
      idle();
      sr(8'h40);
      $display("t_gate done");
   endtask
   initial begin
      repeat (4) @(posedge i_clk);
      #5 i_rst = 1'b0;
      repeat (4) @(posedge i_clk);
      t_prot();
      t_sect();
      t_otp();
      t_gate();
      finish_test();
   end
endmodule // prot_cmd_top_bench
`default_nettype wire
